// ---- hw/uart_dma_consts.vh ----
`ifndef UART_DMA_CONSTS_VH
`define UART_DMA_CONSTS_VH

// ----------------------------------------
// Register word indices (byte address = 4 * index)
// ----------------------------------------
`define IDX_IER 4'h1
`define IDX_FCR 4'h2
`define IDX_STAT 4'h8
`define IDX_MASK 4'h9
`define IDX_DMA 4'hA

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define FCR_EN 0
`define FCR_DMA 3
`define FCR_TXT_LO 4
`define FCR_TXT_HI 5
`define FCR_RXT_LO 6
`define FCR_RXT_HI 7
`define IER_RXDATA 0
`define IER_TXEMPTY 1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_SEL 2'h0
`define RST_IER 2'h0
`define RST_EV 3'h0

// ----------------------------------------
// Receive trigger levels and transmit thresholds
// ----------------------------------------
`define RXT16_3 7'h0E
`define RXT16_2 7'h08
`define RXT16_1 7'h04
`define RXT16_0 7'h01
`define RXT64_3 7'h3C
`define RXT64_2 7'h38
`define RXT64_1 7'h10
`define RXT64_0 7'h08
`define TXT_3 7'h38
`define TXT_2 7'h20
`define TXT_1 7'h10
`define TXT_0 7'h08
`define DEPTH_16 7'h10
`define DEPTH_64 7'h40

// ----------------------------------------
// Receive timeout: chars shift (x4) plus extra bit times
// ----------------------------------------
`define TO_CHAR_SHIFT 2
`define TO_EXTRA_BITS 7'h0C

// ----------------------------------------
// Ident codes, events, bus responses
// ----------------------------------------
`define IIR_NONE 4'h1
`define IIR_TIMEOUT 4'hC
`define IIR_RXDATA 4'h4
`define IIR_TXEMPTY 4'h2
`define EV_RXTRIG 0
`define EV_TIMEOUT 1
`define EV_TXREQ 2
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- hw/axil_reg_port.v ----
`timescale 1ns/1ps
`include "uart_dma_consts.vh"

module axil_reg_port (
	input wire aclk,
	input wire aresetn,
	input wire clk_en,
	input wire [5:0] awaddr,
	input wire awvalid,
	output reg awready,
	input wire [31:0] wdata,
	input wire [3:0] wstrb,
	input wire wvalid,
	output reg wready,
	output reg [1:0] bresp,
	output reg bvalid,
	input wire bready,
	input wire [5:0] araddr,
	input wire arvalid,
	output reg arready,
	output reg [31:0] rdata,
	output reg [1:0] rresp,
	output reg rvalid,
	input wire rready,
	output wire wr_en,
	output wire [3:0] wr_idx,
	output wire [7:0] wr_data,
	output wire wr_lane0,
	input wire wr_err,
	output wire [3:0] rd_idx,
	input wire [31:0] rd_data,
	input wire rd_err
);

reg have_aw_r;
reg have_w_r;
reg [3:0] aw_idx_r;
reg [7:0] w_data_r;
reg w_lane0_r;

// Write fires once both halves are held
assign wr_en = clk_en & have_aw_r & have_w_r & ~bvalid;
assign wr_idx = aw_idx_r;
assign wr_data = w_data_r;
assign wr_lane0 = w_lane0_r;
assign rd_idx = araddr[5:2];

// Write channels, taken in either order
always @(posedge aclk) begin
	if (!aresetn) begin
		awready <= 1'b0;
		wready <= 1'b0;
		have_aw_r <= 1'b0;
		have_w_r <= 1'b0;
		aw_idx_r <= 4'h0;
		w_data_r <= 8'h00;
		w_lane0_r <= 1'b0;
		bvalid <= 1'b0;
		bresp <= `RESP_OKAY;
	end else if (clk_en) begin
		if (awvalid && awready) begin
			have_aw_r <= 1'b1;
			aw_idx_r <= awaddr[5:2];
			awready <= 1'b0;
		end else if (!have_aw_r && !bvalid) begin
			awready <= 1'b1;
		end
		if (wvalid && wready) begin
			have_w_r <= 1'b1;
			w_data_r <= wdata[7:0];
			w_lane0_r <= wstrb[0];
			wready <= 1'b0;
		end else if (!have_w_r && !bvalid) begin
			wready <= 1'b1;
		end
		if (wr_en) begin
			have_aw_r <= 1'b0;
			have_w_r <= 1'b0;
			bvalid <= 1'b1;
			bresp <= wr_err ? `RESP_SLVERR : `RESP_OKAY;
		end else if (bvalid && bready) begin
			bvalid <= 1'b0;
		end
	end
end

// Read channel, data captured at the address handshake
always @(posedge aclk) begin
	if (!aresetn) begin
		arready <= 1'b0;
		rvalid <= 1'b0;
		rdata <= 32'h00000000;
		rresp <= `RESP_OKAY;
	end else if (clk_en) begin
		if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_err ? 32'h00000000 : rd_data;
			rresp <= rd_err ? `RESP_SLVERR : `RESP_OKAY;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end else if (!rvalid) begin
			arready <= 1'b1;
		end
	end
end

endmodule

// ---- hw/rx_idle_timer.v ----
`timescale 1ns/1ps
`include "uart_dma_consts.vh"

module rx_idle_timer (
	input wire aclk,
	input wire aresetn,
	input wire clk_en,
	input wire bit_tick,
	input wire [3:0] char_bits,
	input wire rx_held,
	input wire rx_activity,
	output reg timeout
);

reg [6:0] cnt_r;
wire [6:0] limit;

// Four character times plus twelve bit times
assign limit = ({3'h0, char_bits} << `TO_CHAR_SHIFT) + `TO_EXTRA_BITS;

// Counts bit times while data sits unread
always @(posedge aclk) begin
	if (!aresetn) begin
		cnt_r <= 7'h00;
		timeout <= 1'b0;
	end else if (clk_en) begin
		if (!rx_held || rx_activity) begin
			cnt_r <= 7'h00;
			timeout <= 1'b0;
		end else if (bit_tick && !timeout) begin
			if (cnt_r == limit - 7'h01) begin
				timeout <= 1'b1;
			end else begin
				cnt_r <= cnt_r + 7'h01;
			end
		end
	end
end

endmodule

// ---- hw/uart_fifo_dma_request.v ----
`timescale 1ns/1ps
`include "uart_dma_consts.vh"

module uart_fifo_dma_request #(
	parameter DEEP64 = 0
) (
	input wire aclk,
	input wire aresetn,
	input wire clk_en,
	input wire [5:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [5:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [6:0] rx_count,
	input wire [6:0] tx_count,
	input wire rx_push,
	input wire rx_pop,
	input wire bit_tick,
	input wire [3:0] char_bits,
	output reg rx_dma_request_n,
	output reg tx_dma_request_n,
	output reg rx_data_avail_int,
	output reg fifo_enable,
	output reg irq
);

// ----------------------------------------
// Level lookups
// ----------------------------------------

// Receive trigger level per variant
function [6:0] rx_level;
	input [1:0] sel;
	input deep;
	begin
		case ({deep, sel})
		3'h0: rx_level = `RXT16_0;
		3'h1: rx_level = `RXT16_1;
		3'h2: rx_level = `RXT16_2;
		3'h3: rx_level = `RXT16_3;
		3'h4: rx_level = `RXT64_0;
		3'h5: rx_level = `RXT64_1;
		3'h6: rx_level = `RXT64_2;
		default: rx_level = `RXT64_3;
		endcase
	end
endfunction

// Transmit empty-space threshold, deep variant only
function [6:0] tx_level;
	input [1:0] sel;
	begin
		case (sel)
		2'h0: tx_level = `TXT_0;
		2'h1: tx_level = `TXT_1;
		2'h2: tx_level = `TXT_2;
		default: tx_level = `TXT_3;
		endcase
	end
endfunction

// ----------------------------------------
// State
// ----------------------------------------
reg dma_mode_r;
reg [1:0] rx_sel_r;
reg [1:0] tx_sel_r;
reg [1:0] ier_r;
reg [2:0] stat_r;
reg [2:0] mask_r;
reg rx_burst_r;
reg tx_burst_r;
reg trig_seen_r;
reg to_seen_r;
reg rx_burst_nxt;
reg tx_burst_nxt;
reg [2:0] stat_nxt;
reg [31:0] rd_data;
reg rd_err;
reg [3:0] ident;

wire wr_en;
wire [3:0] wr_idx;
wire [7:0] wr_data;
wire wr_lane0;
wire [3:0] rd_idx;
wire wr_err;
wire rx_timeout;
wire rx_held = rx_count != 7'h00;

// ----------------------------------------
// Bus port and timeout timer
// ----------------------------------------
axil_reg_port u_port (
	.aclk(aclk),
	.aresetn(aresetn),
	.clk_en(clk_en),
	.awaddr(s_axi_awaddr),
	.awvalid(s_axi_awvalid),
	.awready(s_axi_awready),
	.wdata(s_axi_wdata),
	.wstrb(s_axi_wstrb),
	.wvalid(s_axi_wvalid),
	.wready(s_axi_wready),
	.bresp(s_axi_bresp),
	.bvalid(s_axi_bvalid),
	.bready(s_axi_bready),
	.araddr(s_axi_araddr),
	.arvalid(s_axi_arvalid),
	.arready(s_axi_arready),
	.rdata(s_axi_rdata),
	.rresp(s_axi_rresp),
	.rvalid(s_axi_rvalid),
	.rready(s_axi_rready),
	.wr_en(wr_en),
	.wr_idx(wr_idx),
	.wr_data(wr_data),
	.wr_lane0(wr_lane0),
	.wr_err(wr_err),
	.rd_idx(rd_idx),
	.rd_data(rd_data),
	.rd_err(rd_err)
);

rx_idle_timer u_timer (
	.aclk(aclk),
	.aresetn(aresetn),
	.clk_en(clk_en),
	.bit_tick(bit_tick),
	.char_bits(char_bits),
	.rx_held(rx_held),
	.rx_activity(rx_push | rx_pop),
	.timeout(rx_timeout)
);

// ----------------------------------------
// Level and threshold comparisons
// ----------------------------------------
wire mode1 = fifo_enable & dma_mode_r;
wire [6:0] depth = DEEP64 ? `DEPTH_64 : `DEPTH_16;
wire [6:0] rx_trig = fifo_enable ? rx_level(rx_sel_r, DEEP64 != 0) : `RXT16_0;
wire rx_at_trig = rx_count >= rx_trig;
wire tx_empty = tx_count == 7'h00;
wire tx_full = tx_count >= depth;
wire [6:0] tx_space = depth - tx_count;
wire tx_open = DEEP64 ? (tx_space > tx_level(tx_sel_r)) : tx_empty;
wire rx_req = mode1 ? rx_burst_nxt : rx_held;
wire tx_req = mode1 ? tx_burst_nxt : tx_empty;
wire [2:0] events;
wire fcr_wr = wr_en & wr_lane0 & (wr_idx == `IDX_FCR);

assign events[`EV_RXTRIG] = rx_at_trig & ~trig_seen_r;
assign events[`EV_TIMEOUT] = rx_timeout & ~to_seen_r;
assign events[`EV_TXREQ] = tx_req & tx_dma_request_n;
assign wr_err = (wr_idx != `IDX_IER) && (wr_idx != `IDX_FCR) &&
	(wr_idx != `IDX_STAT) && (wr_idx != `IDX_MASK);

// Burst request latches for mode 1
always @* begin
	rx_burst_nxt = rx_burst_r;
	tx_burst_nxt = tx_burst_r;
	if (!mode1) begin
		rx_burst_nxt = 1'b0;
		tx_burst_nxt = 1'b0;
	end else begin
		if (!rx_held) begin
			rx_burst_nxt = 1'b0;
		end else if (rx_count == rx_trig || rx_timeout) begin
			rx_burst_nxt = 1'b1;
		end
		if (tx_full) begin
			tx_burst_nxt = 1'b0;
		end else if (tx_open) begin
			tx_burst_nxt = 1'b1;
		end
	end
end

// Sticky status: a new event wins over write-one-to-clear
always @* begin
	stat_nxt = stat_r;
	if (wr_en && wr_lane0 && wr_idx == `IDX_STAT) begin
		stat_nxt = stat_r & ~wr_data[2:0];
	end
	stat_nxt = stat_nxt | events;
end

// Interrupt ident value returned at the control address
always @* begin
	if (rx_timeout && ier_r[`IER_RXDATA]) begin
		ident = `IIR_TIMEOUT;
	end else if (rx_data_avail_int) begin
		ident = `IIR_RXDATA;
	end else if (tx_empty && ier_r[`IER_TXEMPTY]) begin
		ident = `IIR_TXEMPTY;
	end else begin
		ident = `IIR_NONE;
	end
end

// Read decode; of the control register only the enable bit reads back, twice, at bits 7:6
always @* begin
	rd_err = 1'b0;
	case (rd_idx)
	`IDX_IER: rd_data = {30'h00000000, ier_r};
	`IDX_FCR: rd_data = {24'h000000, {2{fifo_enable}}, 2'h0, ident};
	`IDX_STAT: rd_data = {29'h00000000, stat_r};
	`IDX_MASK: rd_data = {29'h00000000, mask_r};
	`IDX_DMA: rd_data = {24'h000000, rx_count[5:0], tx_burst_r, rx_burst_r};
	default: begin
		rd_data = 32'h00000000;
		rd_err = 1'b1;
	end
	endcase
end

// ----------------------------------------
// Registers
// ----------------------------------------

// Software-visible control
always @(posedge aclk) begin
	if (!aresetn) begin
		fifo_enable <= 1'b0;
		dma_mode_r <= 1'b0;
		rx_sel_r <= `RST_SEL;
		tx_sel_r <= `RST_SEL;
		ier_r <= `RST_IER;
		mask_r <= `RST_EV;
	end else if (clk_en) begin
		if (fcr_wr) begin
			fifo_enable <= wr_data[`FCR_EN];
			if (fifo_enable && wr_data[`FCR_EN]) begin
				dma_mode_r <= wr_data[`FCR_DMA];
				rx_sel_r <= wr_data[`FCR_RXT_HI:`FCR_RXT_LO];
				if (DEEP64) begin
					tx_sel_r <= wr_data[`FCR_TXT_HI:`FCR_TXT_LO];
				end
			end
		end
		if (wr_en && wr_lane0 && wr_idx == `IDX_IER) begin
			ier_r <= wr_data[1:0];
		end
		if (wr_en && wr_lane0 && wr_idx == `IDX_MASK) begin
			mask_r <= wr_data[2:0];
		end
	end
end

// Request pins, interrupt flags and event edges
always @(posedge aclk) begin
	if (!aresetn) begin
		rx_burst_r <= 1'b0;
		tx_burst_r <= 1'b0;
		rx_dma_request_n <= 1'b1;
		tx_dma_request_n <= 1'b1;
		rx_data_avail_int <= 1'b0;
		trig_seen_r <= 1'b0;
		to_seen_r <= 1'b0;
		stat_r <= `RST_EV;
		irq <= 1'b0;
	end else if (clk_en) begin
		rx_burst_r <= rx_burst_nxt;
		tx_burst_r <= tx_burst_nxt;
		rx_dma_request_n <= ~rx_req;
		tx_dma_request_n <= ~tx_req;
		rx_data_avail_int <= ier_r[`IER_RXDATA] & rx_at_trig;
		trig_seen_r <= rx_at_trig;
		to_seen_r <= rx_timeout;
		stat_r <= stat_nxt;
		irq <= |(stat_nxt & mask_r);
	end
end

endmodule

// ---- tb/dma_req_monitor.sv ----
`timescale 1ns/1ps
module dma_req_monitor #(
	parameter DEEP64 = 0
) (
	input wire aclk,
	input wire aresetn,
	input wire clk_en,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [6:0] rx_count,
	input wire [6:0] tx_count,
	input wire rx_dma_request_n,
	input wire tx_dma_request_n,
	input wire rx_data_avail_int,
	input wire fifo_enable
);
	localparam logic [6:0] DEPTH = DEEP64 ? 7'h40 : 7'h10;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn || !clk_en);
	// ----------------------------------------
	// Bus handshakes
	// ----------------------------------------
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_write_answer: assert property (wr_taken |=> ##1 s_axi_bvalid)
		else $error("write answer missing");
	a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
		else $error("read answer missing");
	a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	a_write_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response not held");
	// ----------------------------------------
	// Request pins
	// ----------------------------------------
	a_rx_single_mode: assert property (!fifo_enable |=> rx_dma_request_n == ($past(rx_count) == 7'h00))
		else $error("receive request wrong with fifos off");
	a_tx_single_mode: assert property (!fifo_enable |=> tx_dma_request_n == ($past(tx_count) != 7'h00))
		else $error("transmit request wrong with fifos off");
	a_rx_empty_off: assert property (rx_count == 7'h00 |=> rx_dma_request_n)
		else $error("receive request low while empty");
	a_rx_burst_hold: assert property (!rx_dma_request_n && rx_count != 7'h00 |=> !rx_dma_request_n)
		else $error("receive request dropped early");
	a_tx_empty_req: assert property (tx_count == 7'h00 |=> !tx_dma_request_n)
		else $error("transmit request missing while empty");
	a_tx_full_off: assert property (tx_count >= DEPTH |=> tx_dma_request_n)
		else $error("transmit request low while full");
	a_int_empty_off: assert property (rx_count == 7'h00 |=> !rx_data_avail_int)
		else $error("data interrupt while empty");
endmodule

bind uart_fifo_dma_request dma_req_monitor #(.DEEP64(DEEP64)) mon (.aclk, .aresetn, .clk_en,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
	.rx_count, .tx_count, .rx_dma_request_n, .tx_dma_request_n, .rx_data_avail_int, .fifo_enable);

// ---- tb/dma_partner.sv ----
`timescale 1ns/1ps
module dma_partner #(
	parameter DEPTH = 7'h10
) (
	input wire aclk,
	input wire aresetn,
	input wire rx_dma_request_n,
	input wire tx_dma_request_n,
	input wire dma_on,
	input wire rx_arrive,
	input wire tx_send,
	output reg [6:0] rx_count,
	output reg [6:0] tx_count,
	output reg rx_push,
	output reg rx_pop,
	output reg bit_tick,
	output wire [3:0] char_bits
);
	reg [1:0] tick_r;
	reg fill_r;
	reg fill_q;
	// Serve one character per request, gap covers pin latency
	wire pop_nxt = dma_on && !rx_dma_request_n && rx_count != 7'h00 && !rx_pop;
	wire fill_nxt = dma_on && !tx_dma_request_n && tx_count < DEPTH && !fill_r && !fill_q;
	assign char_bits = 4'hA;
	// Levels, pulses and bit time (one tick per four cycles)
	always @(posedge aclk) begin
		if (!aresetn) begin
			tick_r <= 2'h0;
			fill_r <= 1'h0;
			fill_q <= 1'h0;
			bit_tick <= 1'h0;
			rx_push <= 1'h0;
			rx_pop <= 1'h0;
			rx_count <= 7'h00;
			tx_count <= 7'h00;
		end else begin
			tick_r <= tick_r + 2'h1;
			bit_tick <= tick_r == 2'h3;
			rx_push <= rx_arrive;
			rx_pop <= pop_nxt;
			fill_r <= fill_nxt;
			fill_q <= fill_r;
			rx_count <= rx_count + {6'h00, rx_arrive} - {6'h00, pop_nxt};
			tx_count <= tx_count + {6'h00, fill_nxt} - {6'h00, tx_send && tx_count != 7'h00};
		end
	end
endmodule

// ---- tb/test_uart_fifo_dma_request.sv ----
`timescale 1ns/1ps
module test_uart_fifo_dma_request;
	reg aclk = 1'h0;
	reg aresetn = 1'h0;
	reg [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
	reg [31:0] s_axi_wdata = 32'h0;
	reg s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	reg s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	reg dma_on = 1'h0, rx_arrive = 1'h0, tx_send = 1'h0;
	reg clk_en = 1'h1;
	wire rx_deep_n, tx_deep_n, int_deep;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [6:0] rx_count, tx_count;
	wire [3:0] char_bits;
	wire rx_push, rx_pop, bit_tick, rx_dma_request_n, tx_dma_request_n;
	wire rx_data_avail_int, fifo_enable, irq;
	integer n_fail = 0, checks = 0;

	uart_fifo_dma_request #(.DEEP64(0)) dut (.aclk, .aresetn, .clk_en, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_count,
		.tx_count, .rx_push, .rx_pop, .bit_tick, .char_bits, .rx_dma_request_n, .tx_dma_request_n,
		.rx_data_avail_int, .fifo_enable, .irq);
	// Deep variant on the same bus and levels; only its pins are checked
	uart_fifo_dma_request #(.DEEP64(1)) dut64 (.aclk, .aresetn, .clk_en, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready(), .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
		.s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(),
		.s_axi_rready, .rx_count, .tx_count, .rx_push, .rx_pop, .bit_tick, .char_bits,
		.rx_dma_request_n(rx_deep_n), .tx_dma_request_n(tx_deep_n),
		.rx_data_avail_int(int_deep), .fifo_enable(), .irq());
	dma_partner #(.DEPTH(7'h10)) far (.aclk, .aresetn, .rx_dma_request_n, .tx_dma_request_n,
		.dma_on, .rx_arrive, .tx_send, .rx_count, .tx_count, .rx_push, .rx_pop, .bit_tick,
		.char_bits);

	// Clock at 100 ns
	always #50 aclk = ~aclk;

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task conclude;
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input string what, input [31:0] seen, input [31:0] exp);
		checks = checks + 1;
		if (seen !== exp) begin
			n_fail = n_fail + 1;
			$display("unexpected %0s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task wr(input [5:0] a, input [7:0] d, input [1:0] er);
		integer i;
		begin
			@(posedge aclk);
			s_axi_awaddr <= a;
			s_axi_wdata <= {24'h000000, d};
			s_axi_awvalid <= 1'h1;
			s_axi_wvalid <= 1'h1;
			s_axi_bready <= 1'h1;
			for (i = 0; i < 40; i = i + 1) begin
				@(posedge aclk);
				if (s_axi_awready) s_axi_awvalid <= 1'h0;
				if (s_axi_wready) s_axi_wvalid <= 1'h0;
				if (s_axi_bvalid) break;
			end
			if (i == 40) begin n_fail = n_fail + 1; conclude; end
			s_axi_bready <= 1'h0;
			chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
		end
	endtask
	task rd(input [5:0] a, input [31:0] ed, input [1:0] er);
		integer i;
		begin
			@(posedge aclk);
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'h1;
			s_axi_rready <= 1'h1;
			for (i = 0; i < 40; i = i + 1) begin
				@(posedge aclk);
				if (s_axi_arready) s_axi_arvalid <= 1'h0;
				if (s_axi_rvalid) break;
			end
			if (i == 40) begin n_fail = n_fail + 1; conclude; end
			s_axi_rready <= 1'h0;
			chk("rdata", s_axi_rdata, ed);
			chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
		end
	endtask
	task arrive(input integer n);
		repeat (n) begin
			@(posedge aclk);
			rx_arrive <= 1'h1;
		end
		@(posedge aclk);
		rx_arrive <= 1'h0;
		repeat (3) @(posedge aclk);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (3) @(posedge aclk);
		chk("tx request", tx_dma_request_n, 0);
		chk("irq", irq, 0);
		wr(6'h08, 8'hC9, 2'h0);
		chk("fifo enable", fifo_enable, 1);
		rd(6'h08, 32'hC1, 2'h0);
		rd(6'h04, 32'h00, 2'h0);
		rd(6'h3C, 32'h00, 2'h2);
		wr(6'h28, 8'h01, 2'h2);
		$display("test reset and map done");
		wr(6'h08, 8'h01, 2'h0);
		rd(6'h08, 32'hC1, 2'h0);
		clk_en <= 1'h0;
		arrive(1);
		chk("frozen rx request", rx_dma_request_n, 1);
		clk_en <= 1'h1;
		repeat (2) @(posedge aclk);
		chk("rx request", rx_dma_request_n, 0);
		dma_on <= 1'h1;
		repeat (20) @(posedge aclk);
		chk("rx request", rx_dma_request_n, 1);
		chk("tx level", tx_count, 1);
		$display("test single transfer done");
		wr(6'h08, 8'hC9, 2'h0);
		@(posedge aclk);
		tx_send <= 1'h1;
		@(posedge aclk);
		tx_send <= 1'h0;
		repeat (80) @(posedge aclk);
		chk("tx level", tx_count, 16);
		chk("tx request", tx_dma_request_n, 1);
		chk("tx request 64", tx_deep_n, 0);
		dma_on <= 1'h0;
		wr(6'h04, 8'h01, 2'h0);
		wr(6'h20, 8'h07, 2'h0);
		arrive(13);
		chk("rx request", rx_dma_request_n, 1);
		chk("data int", rx_data_avail_int, 0);
		arrive(1);
		chk("rx request", rx_dma_request_n, 0);
		chk("data int", rx_data_avail_int, 1);
		chk("rx request 64", rx_deep_n, 1);
		chk("data int 64", int_deep, 0);
		rd(6'h08, 32'hC4, 2'h0);
		rd(6'h20, 32'h01, 2'h0);
		wr(6'h24, 8'h01, 2'h0);
		repeat (2) @(posedge aclk);
		chk("irq", irq, 1);
		wr(6'h20, 8'h01, 2'h0);
		repeat (2) @(posedge aclk);
		chk("irq", irq, 0);
		dma_on <= 1'h1;
		repeat (40) @(posedge aclk);
		chk("rx request", rx_dma_request_n, 1);
		chk("rx level", rx_count, 0);
		$display("test burst transfer done");
		dma_on <= 1'h0;
		arrive(2);
		repeat (180) @(posedge aclk);
		chk("rx request", rx_dma_request_n, 1);
		repeat (60) @(posedge aclk);
		chk("rx request", rx_dma_request_n, 0);
		chk("irq", irq, 0);
		rd(6'h20, 32'h02, 2'h0);
		rd(6'h08, 32'hCC, 2'h0);
		dma_on <= 1'h1;
		repeat (20) @(posedge aclk);
		chk("rx request", rx_dma_request_n, 1);
		$display("test receive timeout done");
		conclude;
	end
endmodule
